/* hw/openload_on_summary_flag_loop_pkg.sv */
// constants, codes and timing for the open-load-at-on diagnosis loop
package openload_on_summary_flag_loop_pkg;

   // channel count and the auto-configurable high-side channels (2..7)
   localparam int NUM_CH = 8;
   localparam logic [7:0] AUTO_CH_MASK = 8'hfc;

   // select field codes
   localparam logic [3:0] SEL_CH_FIRST = 4'h2;
   localparam logic [3:0] SEL_CH_LAST = 4'h7;
   localparam logic [3:0] SEL_LOOP = 4'ha;
   localparam logic [3:0] SEL_IDLE = 4'hf;
   localparam logic [3:0] SEL_RESET = SEL_IDLE;

   // register byte offsets on the avalon slave
   localparam logic [3:0] OFS_SELECT = 4'h0;
   localparam logic [3:0] OFS_RESULT = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;

   // status register field positions
   localparam int STAT_SUMMARY_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;

   // reset values
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // clock and the one microsecond timing tick
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

   // diagnosis times in microseconds, counted in ticks
   localparam int DIAG_SETTLING_TIME_US = 40;
   localparam int DIAG_CHANNEL_SWITCH_TIME_US = 20;
   localparam int ON_WAIT_TIME_US = 58;
   localparam int SYNC_DELAY_US = 1;
   localparam int TICK_US = TICK_NS / 1000;
   localparam logic [7:0] T_DIR_FIRST =
      8'((DIAG_SETTLING_TIME_US + SYNC_DELAY_US) / TICK_US);
   localparam logic [7:0] T_DIR_STEP =
      8'((DIAG_CHANNEL_SWITCH_TIME_US + SYNC_DELAY_US) / TICK_US);
   localparam logic [7:0] T_PWM_SETTLE = 8'(DIAG_SETTLING_TIME_US / TICK_US);
   localparam logic [7:0] T_PWM_MEAS =
      8'((ON_WAIT_TIME_US + DIAG_CHANNEL_SWITCH_TIME_US) / TICK_US);
   localparam logic [7:0] T_PWM_STEP =
      8'(DIAG_CHANNEL_SWITCH_TIME_US / TICK_US);

   // lowest set channel of a mask
   function automatic logic [2:0] first_set(input logic [7:0] mask);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (mask[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

endpackage

/* hw/diag_timer_if.sv */
// carrier between the loop sequencer and its wait timer
`timescale 1ns/1ns
interface diag_timer_if;
   logic start;
   logic [7:0] load_us;
   logic done;
   logic tick;
   modport ctrl (output start, output load_us, input done, input tick);
   modport timer (input start, input load_us, output done, output tick);
endinterface

/* hw/diag_wait_timer.sv */
// microsecond tick divider and down-counting wait timer
`timescale 1ns/1ns
module diag_wait_timer (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   diag_timer_if.timer tmr
);
   import openload_on_summary_flag_loop_pkg::*;

   logic [3:0] div_reg;
   logic tick_reg;
   logic [7:0] cnt_reg;
   logic busy_reg;
   logic done_reg;

   assign tmr.tick = tick_reg;
   assign tmr.done = done_reg;

   // divider gives a one-cycle tick every microsecond
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         div_reg <= 4'h0;
         tick_reg <= 1'b0;
      end else if (div_reg == 4'(TICK_CYC - 1)) begin
         div_reg <= 4'h0;
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 4'h1;
         tick_reg <= 1'b0;
      end
   end

   // counts whole ticks; done pulses once the load has run out
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_reg <= 8'h00;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (tmr.start) begin
         cnt_reg <= tmr.load_us;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
      end else if (busy_reg && tick_reg) begin
         if (cnt_reg <= 8'h01) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg - 8'h01;
            done_reg <= 1'b0;
         end
      end else begin
         done_reg <= 1'b0;
      end
   end
endmodule

/* hw/level_sync2.sv */
// two flip-flop synchroniser for a level from the analog side
`timescale 1ns/1ns
module level_sync2 (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_reg;
   logic sync_reg;

   assign sync_o = sync_reg;

   // first stage feeds only the second
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end
endmodule

/* hw/open_load_on_diag_loop.sv */
// open-load-at-on diagnosis loop sequencer with avalon register slave
//
// Behaviour
// - writing the loop code to the select field starts a diagnosis loop
// - the loop steps the diagnosis multiplexer itself, no host command
// - directly driven channels are tested before pwm-driven channels
// - the first directly driven channel examined is the lowest one, channel two when it is direct
// - direct result after settle plus sync, next ones switch plus sync
// - a direct channel that is off gets a zero result
// - channels on pwm generator zero are tested before generator one
// - first pwm channel: settle, next switch-on, then on-wait plus switch
// - each further pwm channel that is on is resolved after the switching time
// - an off pwm channel waits for its on phase, then on-wait plus switch
// - after a wait for switch-on, an on phase shorter than on-wait plus switch stores zero
// - at loop end select returns to idle and results are held
// - summary flag is one for an open load, else zero
// - single channel code: flag shows that channel, refreshed at readout
// - loop code: flag is the or of all results while running
// - idle code: flag holds its last value, the loop outcome after a completed loop
// - reserved select codes give a zero flag; host must not use them
// - after reset the diagnosis is inactive with select at idle
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module open_load_on_diag_loop (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [openload_on_summary_flag_loop_pkg::NUM_CH-1:0] ch_on_i,
   input wire logic [openload_on_summary_flag_loop_pkg::NUM_CH-1:0] ch_pwm_en_i,
   input wire logic [openload_on_summary_flag_loop_pkg::NUM_CH-1:0] ch_pwm_gen_i,
   input wire logic ol_detect_i,
   output logic [2:0] diag_mux_ch_o,
   output logic diag_mux_en_o,
   output logic [openload_on_summary_flag_loop_pkg::NUM_CH-1:0] openload_on_channel_result_o,
   output logic openload_on_summary_flag_o,
   output logic [3:0] openload_on_channel_select_o,
   output logic loop_busy_o
);
   import openload_on_summary_flag_loop_pkg::*;
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DIR_WAIT,
      ST_PWM_SETTLE,
      ST_PWM_ARM,
      ST_PWM_MEAS,
      ST_PWM_STEP
   } loop_state_type;

   diag_timer_if tmr ();

   loop_state_type state_reg;
   logic [3:0] select_reg;
   logic [7:0] result_reg;
   logic summary_reg;
   logic [7:0] dir_left_reg, pwm0_left_reg, pwm1_left_reg;
   logic [2:0] mux_ch_reg;
   logic mux_en_reg, on_lost_reg, fin_reg;
   logic [7:0] on_prev_reg;
   logic tmr_start_reg;
   logic [7:0] tmr_load_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic ol_det_sync;
   logic req, acc, wr_sel, start_loop, stop_loop, rd_status;
   logic sel_single, cur_on, cur_rise;
   logic [7:0] dir_start, pwm0_start, pwm1_start, pwm_left;
   logic [2:0] pwm_next;
   logic [7:0] pwm_next_bit;

   // comparator output crosses from the analog side
   level_sync2 u_det_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i(ol_detect_i),
      .sync_o(ol_det_sync)
   );
   diag_wait_timer u_timer (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .tmr(tmr.timer)
   );
   assign tmr.start = tmr_start_reg;
   assign tmr.load_us = tmr_load_reg;

   // bus decode; an access completes at the edge where waitrequest is low
   assign req = avs_read_i | avs_write_i;
   assign acc = req & ~wait_reg;
   assign wr_sel = acc & avs_write_i & (avs_address_i == OFS_SELECT)
                   & avs_byteenable_i[0];
   assign start_loop = wr_sel & (avs_writedata_i[3:0] == SEL_LOOP);
   assign stop_loop = wr_sel & (avs_writedata_i[3:0] != SEL_LOOP);
   assign rd_status = acc & avs_read_i & (avs_address_i == OFS_STATUS);
   assign sel_single = (select_reg >= SEL_CH_FIRST)
                       && (select_reg <= SEL_CH_LAST);

   // channel currently on the multiplexer and its switch-on edge
   assign cur_on = ch_on_i[mux_ch_reg];
   assign cur_rise = ch_on_i[mux_ch_reg] & ~on_prev_reg[mux_ch_reg];

   // scan sets taken from the channel mapping at loop start
   assign dir_start = AUTO_CH_MASK & ~ch_pwm_en_i;
   assign pwm0_start = AUTO_CH_MASK & ch_pwm_en_i & ~ch_pwm_gen_i;
   assign pwm1_start = AUTO_CH_MASK & ch_pwm_en_i & ch_pwm_gen_i;

   // generator zero channels are drained before generator one
   assign pwm_left = (pwm0_left_reg != 8'h00) ? pwm0_left_reg
                                              : pwm1_left_reg;
   assign pwm_next = first_set(pwm_left);
   assign pwm_next_bit = 8'h01 << pwm_next;

   // waitrequest drops for one cycle per request
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= ~(req & wait_reg);
      end
   end

   // read data are registered in the cycle waitrequest falls
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read_i && wait_reg) begin
         case (avs_address_i)
            OFS_SELECT: rdata_reg <= {28'h000_0000, select_reg};
            OFS_RESULT: rdata_reg <= {24'h00_0000, result_reg};
            OFS_STATUS: begin
               rdata_reg <= 32'h0000_0000;
               rdata_reg[STAT_BUSY_BIT] <= (state_reg != ST_IDLE);
               rdata_reg[STAT_SUMMARY_BIT] <= sel_single
                  ? result_reg[select_reg[2:0]] : summary_reg;
            end
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // previous channel on states for switch-on detection
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         on_prev_reg <= 8'h00;
      end else begin
         on_prev_reg <= ch_on_i;
      end
   end

   // select field: host writes, loop end returns it to idle
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         select_reg <= SEL_RESET;
      end else if (wr_sel) begin
         select_reg <= avs_writedata_i[3:0];
      end else if (fin_reg) begin
         select_reg <= SEL_IDLE;
      end
   end

   // loop sequencer: walks the channels and stores each result
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_reg <= ST_IDLE;
         result_reg <= RESULT_RESET;
         dir_left_reg <= 8'h00;
         pwm0_left_reg <= 8'h00;
         pwm1_left_reg <= 8'h00;
         mux_ch_reg <= 3'h0;
         mux_en_reg <= 1'b0;
         on_lost_reg <= 1'b0;
         fin_reg <= 1'b0;
         tmr_start_reg <= 1'b0;
         tmr_load_reg <= 8'h00;
      end else begin
         tmr_start_reg <= 1'b0;
         fin_reg <= 1'b0;
         if (start_loop) begin
            result_reg <= RESULT_RESET;
            mux_en_reg <= 1'b1;
            pwm0_left_reg <= pwm0_start;
            pwm1_left_reg <= pwm1_start;
            tmr_start_reg <= 1'b1;
            if (dir_start != 8'h00) begin
               mux_ch_reg <= first_set(dir_start);
               dir_left_reg <= dir_start & ~(8'h01 << first_set(dir_start));
               tmr_load_reg <= T_DIR_FIRST;
               state_reg <= ST_DIR_WAIT;
            end else begin
               dir_left_reg <= 8'h00;
               state_reg <= ST_PWM_SETTLE;
               tmr_load_reg <= T_PWM_SETTLE;
               if (pwm0_start != 8'h00) begin
                  mux_ch_reg <= first_set(pwm0_start);
                  pwm0_left_reg <= pwm0_start
                                   & ~(8'h01 << first_set(pwm0_start));
               end else begin
                  mux_ch_reg <= first_set(pwm1_start);
                  pwm1_left_reg <= pwm1_start
                                   & ~(8'h01 << first_set(pwm1_start));
               end
               if (pwm0_start == 8'h00 && pwm1_start == 8'h00) begin
                  state_reg <= ST_IDLE;
                  mux_en_reg <= 1'b0;
                  fin_reg <= 1'b1;
               end
            end
         end else if (stop_loop) begin
            state_reg <= ST_IDLE;
            mux_en_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  mux_en_reg <= 1'b0;
               end
               ST_DIR_WAIT: begin
                  if (tmr.done) begin
                     result_reg[mux_ch_reg] <= cur_on & ol_det_sync;
                     tmr_start_reg <= 1'b1;
                     if (dir_left_reg != 8'h00) begin
                        mux_ch_reg <= first_set(dir_left_reg);
                        dir_left_reg <= dir_left_reg
                           & ~(8'h01 << first_set(dir_left_reg));
                        tmr_load_reg <= T_DIR_STEP;
                     end else if (pwm_left != 8'h00) begin
                        mux_ch_reg <= pwm_next;
                        pwm0_left_reg <= pwm0_left_reg & ~pwm_next_bit;
                        pwm1_left_reg <= pwm1_left_reg & ~pwm_next_bit;
                        tmr_load_reg <= T_PWM_SETTLE;
                        state_reg <= ST_PWM_SETTLE;
                     end else begin
                        tmr_start_reg <= 1'b0;
                        mux_en_reg <= 1'b0;
                        fin_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_PWM_SETTLE: begin
                  if (tmr.done) begin
                     state_reg <= ST_PWM_ARM;
                  end
               end
               ST_PWM_ARM: begin
                  // a channel in its off phase waits for the next switch-on
                  if (cur_rise) begin
                     on_lost_reg <= 1'b0;
                     tmr_load_reg <= T_PWM_MEAS;
                     tmr_start_reg <= 1'b1;
                     state_reg <= ST_PWM_MEAS;
                  end
               end
               ST_PWM_MEAS, ST_PWM_STEP: begin
                  if (state_reg == ST_PWM_MEAS && !cur_on) begin
                     on_lost_reg <= 1'b1;
                  end
                  if (tmr.done && state_reg == ST_PWM_STEP && !cur_on) begin
                     state_reg <= ST_PWM_ARM;
                  end else if (tmr.done) begin
                     result_reg[mux_ch_reg] <= ol_det_sync & cur_on
                        & ~(on_lost_reg && state_reg == ST_PWM_MEAS);
                     if (pwm_left != 8'h00) begin
                        mux_ch_reg <= pwm_next;
                        pwm0_left_reg <= pwm0_left_reg & ~pwm_next_bit;
                        pwm1_left_reg <= pwm1_left_reg & ~pwm_next_bit;
                        tmr_load_reg <= T_PWM_STEP;
                        tmr_start_reg <= 1'b1;
                        state_reg <= ST_PWM_STEP;
                     end else begin
                        mux_en_reg <= 1'b0;
                        fin_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
                  mux_en_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // summary flag according to the select field
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         summary_reg <= 1'b0;
      end else if (select_reg == SEL_LOOP) begin
         summary_reg <= |result_reg;
      end else if (select_reg == SEL_IDLE) begin
         if (fin_reg) begin
            summary_reg <= |result_reg;
         end
      end else if (sel_single) begin
         if (rd_status) begin
            summary_reg <= result_reg[select_reg[2:0]];
         end
      end else begin
         summary_reg <= 1'b0;
      end
   end

   // registered outputs
   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign diag_mux_ch_o = mux_ch_reg;
   assign diag_mux_en_o = mux_en_reg;
   assign openload_on_channel_result_o = result_reg;
   assign openload_on_summary_flag_o = summary_reg;
   assign openload_on_channel_select_o = select_reg;
   assign loop_busy_o = mux_en_reg; // mux is driven only while busy

   // named steps used by the checks
   sequence seq_loop_write;
      start_loop && dir_start[2];
   endsequence
   sequence seq_dir_done_off;
      state_reg == ST_DIR_WAIT && tmr.done && !cur_on && !wr_sel;
   endsequence
   chk_loop_starts: assert property (
      start_loop |=> state_reg != ST_IDLE || fin_reg)
      else $error("loop did not start on loop code");
   chk_first_ch_two: assert property (
      seq_loop_write |=> mux_ch_reg == 3'h2 && diag_mux_en_o)
      else $error("first direct channel is not two");
   chk_dir_settle: assert property (
      seq_loop_write ##1 (state_reg == ST_DIR_WAIT && !wr_sel) [*8]
      |-> $stable(result_reg))
      else $error("direct result came before settling");
   chk_off_zero: assert property (
      seq_dir_done_off |=> result_reg[$past(mux_ch_reg)] == 1'b0)
      else $error("off direct channel gave nonzero result");
   chk_pwm_after_dir: assert property (
      state_reg inside {ST_PWM_SETTLE, ST_PWM_ARM, ST_PWM_MEAS}
      |-> dir_left_reg == 8'h00)
      else $error("pwm channel tested before direct ones");
   chk_end_idle: assert property (
      fin_reg && !wr_sel |=> select_reg == SEL_IDLE ##1
      summary_reg == $past(|result_reg, 2))
      else $error("loop end did not restore idle select");
   chk_idle_hold: assert property (
      state_reg == ST_IDLE && !start_loop |=> $stable(result_reg))
      else $error("results changed outside a loop");
   chk_or_flag: assert property (
      select_reg == SEL_LOOP |=> summary_reg == $past(|result_reg))
      else $error("summary is not or of results in loop");
   chk_reserved_zero: assert property (
      !sel_single && select_reg != SEL_LOOP && select_reg != SEL_IDLE
      |=> !summary_reg || $past(wr_sel))
      else $error("reserved select gave nonzero summary");
   chk_reset_idle: assert property (
      disable iff (1'b0)
      srst_i |=> select_reg == SEL_IDLE && !diag_mux_en_o && !loop_busy_o)
      else $error("reset did not leave diagnosis idle");
endmodule

/* dv/load_stage_model.sv */
// load side model: pwm waveforms and the muxed open-load comparator
`timescale 1ns/1ns
module load_stage_model (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [2:0] mux_ch_i,
   input wire logic mux_en_i,
   input wire logic [7:0] open_mask_i,
   output logic ol_detect_o = 1'b0,
   output logic pwm_long_o = 1'b0,
   output logic pwm_short_o = 1'b0
);
   int cnt = 0;
   // 120 us period: long phase 100 us on, short phase 50 us on
   always @(posedge ref_clk_i) begin
      cnt <= (srst_i || cnt == 1199) ? 0 : cnt + 1;
      pwm_long_o <= cnt < 1000;
      pwm_short_o <= cnt < 500;
   end
   // comparator follows the muxed load, wanders when nothing is muxed
   always @(posedge ref_clk_i) begin
      if (mux_en_i) begin
         ol_detect_o <= open_mask_i[mux_ch_i];
      end else begin
         ol_detect_o <= !ol_detect_o;
      end
   end
endmodule

/* dv/tb_open_load_on_diag_loop.sv */
// bench for the open-load-at-on diagnosis loop sequencer
`timescale 1ns/1ns
module tb_open_load_on_diag_loop;
   import openload_on_summary_flag_loop_pkg::*;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] rq, rdat;
   logic wreq, mux_en, flag, busy, ol_det, pl, ps;
   logic [2:0] mux_ch;
   logic [3:0] sel;
   logic [7:0] res, ch_on, dir_on = 8'hff, pwm_en = 8'h00;
   logic [7:0] pwm_gen = 8'h00, open_mask = 8'h00;
   logic [2:0] order_q[$];
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int dur;
   // clock and the channel on states seen by the block
   initial forever #50 ref_clk_i = ~ref_clk_i;
   assign ch_on = (dir_on & ~pwm_en) | (pwm_en & {ps, {7{pl}}});
   // cycle count and the order in which the mux visits channels
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (mux_en === 1'b1 && (order_q.size() == 0 || order_q[$] !== mux_ch))
         order_q.push_back(mux_ch);
   end
   open_load_on_diag_loop open_load_on_diag_loop_i (.ref_clk_i(ref_clk_i),
      .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rq), .avs_waitrequest_o(wreq), .ch_on_i(ch_on),
      .ch_pwm_en_i(pwm_en), .ch_pwm_gen_i(pwm_gen), .ol_detect_i(ol_det),
      .diag_mux_ch_o(mux_ch), .diag_mux_en_o(mux_en),
      .openload_on_channel_result_o(res),
      .openload_on_summary_flag_o(flag),
      .openload_on_channel_select_o(sel), .loop_busy_o(busy));
   load_stage_model load_stage_model_i (.ref_clk_i(ref_clk_i),
      .srst_i(srst_i), .mux_ch_i(mux_ch), .mux_en_i(mux_en),
      .open_mask_i(open_mask), .ol_detect_o(ol_det), .pwm_long_o(pl),
      .pwm_short_o(ps));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a,
         input logic [31:0] d);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do @(posedge ref_clk_i); while (wreq !== 1'b0);
      rdat = rq;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   // start a loop, probe the status once a result shows, wait for the end
   task automatic run_loop(input bit probe);
      int t0;
      int n;
      order_q.delete();
      bus(1'b1, OFS_SELECT, 32'(SEL_LOOP));
      t0 = cyc;
      n = 0;
      repeat (2) @(posedge ref_clk_i);
      while (busy !== 1'b0 && n < 20000) begin
         if (probe && res !== 8'h00) begin
            bus(1'b0, OFS_STATUS, 32'h0);
            check(rdat, 32'h3);
            probe = 0;
         end
         @(posedge ref_clk_i);
         n++;
      end
      dur = cyc - t0;
      check(32'(n < 20000), 32'h1);
   endtask
   task automatic check_order(input logic [2:0] e [6]);
      check(32'(order_q.size()), 32'd6);
      foreach (e[i]) check(32'(order_q[i]), 32'(e[i]));
   endtask
   task automatic test_reset;
      bus(1'b0, OFS_SELECT, 32'h0);
      check(rdat, 32'(SEL_RESET));
      bus(1'b0, OFS_RESULT, 32'h0);
      check(rdat, 32'(RESULT_RESET));
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rdat, 32'h0);
      bus(1'b0, 4'hc, 32'h0);
      check(rdat, 32'h0);
   endtask
   // direct channels, channel 5 off, loads 3 5 6 open
   task automatic test_direct;
      dir_on <= 8'hdf;
      open_mask <= 8'h68;
      repeat (20) @(posedge ref_clk_i);
      run_loop(1'b0);
      check(32'(dur >= 1440 && dur <= 1470), 32'h1);
      check_order('{3'd2, 3'd3, 3'd4, 3'd5, 3'd6, 3'd7});
      check(32'(res), 32'h48);
      bus(1'b0, OFS_SELECT, 32'h0);
      check(rdat, 32'(SEL_IDLE));
      open_mask <= 8'h00;
      repeat (300) @(posedge ref_clk_i);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rdat, 32'h1);
      check(32'(flag), 32'h1);
      check(32'(sel), 32'(SEL_IDLE));
      check(32'(res), 32'h48);
   endtask
   // 2 3 direct, 5 6 on generator 0, 4 7 on generator 1, 7 on too short
   task automatic test_pwm;
      dir_on <= 8'h0c;
      pwm_en <= 8'hf0;
      pwm_gen <= 8'h90;
      open_mask <= 8'ha4;
      repeat (20) @(posedge ref_clk_i);
      run_loop(1'b1);
      check_order('{3'd2, 3'd3, 3'd5, 3'd6, 3'd4, 3'd7});
      check(32'(res), 32'h24);
   endtask
   // single channel selection on the held results 8'h24 of the pwm loop,
   // ignored byte lane, reserved codes
   task automatic test_single;
      logic [3:0] rsv [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he};
      dir_on <= 8'hff;
      pwm_en <= 8'h00;
      open_mask <= 8'h08;
      bus(1'b1, OFS_SELECT, 32'h5);
      repeat (500) @(posedge ref_clk_i);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rdat, 32'h1);
      be <= 4'he;
      bus(1'b1, OFS_SELECT, 32'h4);
      be <= 4'hf;
      bus(1'b0, OFS_SELECT, 32'h0);
      check(rdat, 32'h5);
      bus(1'b1, OFS_SELECT, 32'h3);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rdat, 32'h0);
      check(32'(flag), 32'h0);
      foreach (rsv[i]) begin
         bus(1'b1, OFS_SELECT, 32'(rsv[i]));
         bus(1'b0, OFS_STATUS, 32'h0);
         check(rdat, 32'h0);
         check(32'(flag), 32'h0);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog against a hung handshake or loop
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      n_errors++;
      stop_test;
   end
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      test_reset;
      test_direct;
      test_pwm;
      test_single;
      stop_test;
   end
endmodule
